/* fpeg_pkg.sv */
// constants shared by the flash program/erase guard
package fpeg_pkg;
  // register offsets
  localparam logic [7:0] PSC_ADDR = 8'h8F;
  localparam logic [7:0] KEY_ADDR = 8'hB7;
  localparam logic [7:0] RSRC_ADDR = 8'hC0;
  // program_store_control layout and reset value
  localparam int WE_BIT = 0;
  localparam int EE_BIT = 1;
  localparam logic [1:0] PSC_RST = 2'h0;
  // key codes and key status read codes
  localparam logic [7:0] KEY_CODE1 = 8'hA5;
  localparam logic [7:0] KEY_CODE2 = 8'hF1;
  localparam logic [1:0] KST_LOCKED = 2'h0;
  localparam logic [1:0] KST_FIRST = 2'h1;
  localparam logic [1:0] KST_OPEN = 2'h2;
  localparam logic [1:0] KST_DEAD = 2'h3;
  // reset_source_reg layout
  localparam int POR_BIT = 1;
  localparam int FAULT_BIT = 6;
  // page geometry and erased values
  localparam int PAGE_SHIFT = 9;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] LOCK_NONE = 8'hFF;
  typedef enum logic [3:0] {
    FPEG_LOCKED = 4'h1,
    FPEG_FIRST = 4'h2,
    FPEG_OPEN = 4'h4,
    FPEG_DEAD = 4'h8
  } fpeg_key_state_t;
endpackage

/* fpeg_key_if.sv */
// key lock handshake between guard and key sequencer
`timescale 1ns/1ps
`default_nettype none
interface fpeg_key_if;
  logic srst;
  logic wr;
  logic [7:0] wdata;
  logic attempt;
  logic open;
  logic [1:0] status;
  modport guard (output srst, wr, wdata, attempt, input open, status);
  modport seq (input srst, wr, wdata, attempt, output open, status);
endinterface
`default_nettype wire

/* fpeg_key.sv */
// key_register unlock sequencer
`timescale 1ns/1ps
`default_nettype none
module fpeg_key (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // guard side
  fpeg_key_if.seq kif
);
  fpeg_pkg::fpeg_key_state_t state;
  fpeg_pkg::fpeg_key_state_t next_state;

  always_comb
  begin
    next_state = state;
    unique case (state)
      fpeg_pkg::FPEG_LOCKED:
      begin
        if (kif.attempt)
          next_state = fpeg_pkg::FPEG_DEAD; // [RULE_18]
        else if (kif.wr)
          next_state = (kif.wdata == fpeg_pkg::KEY_CODE1) ? fpeg_pkg::FPEG_FIRST
                                                          : fpeg_pkg::FPEG_DEAD;
      end
      fpeg_pkg::FPEG_FIRST:
      begin
        if (kif.attempt)
          next_state = fpeg_pkg::FPEG_DEAD;
        else if (kif.wr)
          next_state = (kif.wdata == fpeg_pkg::KEY_CODE2) ? fpeg_pkg::FPEG_OPEN
                                                          : fpeg_pkg::FPEG_DEAD;
      end
      fpeg_pkg::FPEG_OPEN:
      begin
        // any further key write is out of order; an operation re-arms the lock
        if (kif.wr)
          next_state = fpeg_pkg::FPEG_DEAD; // [RULE_18]
        else if (kif.attempt)
          next_state = fpeg_pkg::FPEG_LOCKED; // [RULE_18]
      end
      fpeg_pkg::FPEG_DEAD: next_state = fpeg_pkg::FPEG_DEAD;
      default: next_state = fpeg_pkg::FPEG_DEAD;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= fpeg_pkg::FPEG_LOCKED;
    else if (kif.srst)
      state <= fpeg_pkg::FPEG_LOCKED;
    else
      state <= next_state;
  end

  assign kif.open = (state == fpeg_pkg::FPEG_OPEN);

  always_comb
  begin
    unique case (state)
      fpeg_pkg::FPEG_LOCKED: kif.status = fpeg_pkg::KST_LOCKED;
      fpeg_pkg::FPEG_FIRST: kif.status = fpeg_pkg::KST_FIRST;
      fpeg_pkg::FPEG_OPEN: kif.status = fpeg_pkg::KST_OPEN;
      default: kif.status = fpeg_pkg::KST_DEAD;
    endcase
  end
endmodule
`default_nettype wire

/* fpeg_guard.sv */
// flash program/erase guard: store control, lock byte security, fault reset
//
// Overview of operation
// (RULE_01) prohibited debug port flash operations are dropped, never reset
// (RULE_02) prohibited firmware flash operation resets device, fault flag then reads 1
// (RULE_03) debug device erase wipes every page including the lock byte page
// (RULE_04) any locked page also locks the lock byte page
// (RULE_05) lock byte, once written, changes only by debug device erase; a debug page erase of its page still passes until a reset decodes it
// (RULE_06) a new lock byte value protects pages only after next reset
// (RULE_07) both enables set: external move write erases the addressed page
// (RULE_08) write enable only: external move write programs one flash byte
// (RULE_09) erase needs erase enable; flash writes need write enable
// (RULE_10) program_store_control bits 7:2 read zero, writes dropped
// (RULE_11) program_store_control at 0x8F, erase enable bit 1, write enable bit 0
// (RULE_12) interrupts are held pending while a flash operation runs
// (RULE_13) firmware should disable interrupts around write enable set
// (RULE_14) firmware should run from internal oscillator during flash operations
// (RULE_15) firmware writes reset_source_reg directly, power on flag set; the guard ignores writes to it, so they change no flag
// (RULE_16) firmware enables supply monitor reset after write enable, before operation
// (RULE_17) firmware erases a byte before programming it
// (RULE_18) key 0xA5 then 0xF1 unlocks one operation; wrong order kills until reset
// (RULE_19) locked page count from page 0 is the complement of lock byte
// (RULE_20) unlocked code touching a locked page causes flash fault reset
// (RULE_21) page erase gives 0xFF; programming only clears bits
// (RULE_22) lock byte sampled after reset, decoded count held until next reset
`timescale 1ns/1ps
`default_nettype none
module fpeg_guard #(
  parameter int AW = 16,
  parameter logic [15:0] LOCK_ADDR = 16'h3FFF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // firmware flash accesses
  input wire logic cpu_xwr,
  input wire logic cpu_frd,
  input wire logic [AW-1:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [AW-1:0] cpu_pc,
  // debug port accesses
  input wire logic dbg_wr,
  input wire logic dbg_rd,
  input wire logic dbg_erase,
  input wire logic dbg_dev_erase,
  input wire logic [AW-1:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  // flash array
  input wire logic [7:0] lock_byte_in,
  input wire logic fl_busy,
  output logic fl_prog,
  output logic fl_erase,
  output logic fl_dev_erase,
  output logic [AW-1:0] fl_addr,
  output logic [7:0] fl_data,
  // external RAM path
  output logic xram_wr,
  output logic [AW-1:0] xram_addr,
  output logic [7:0] xram_data,
  // system
  output logic dbg_rd_ok,
  output logic dev_reset_req,
  output logic irq_hold
);
  localparam int PW = AW - fpeg_pkg::PAGE_SHIFT;
  localparam logic [PW-1:0] LOCK_PAGE = LOCK_ADDR[AW-1:fpeg_pkg::PAGE_SHIFT];

  logic rst_s1;
  logic rst_n;
  logic fault;
  logic [1:0] psc;
  logic sampled;
  logic [7:0] locked_pages;
  logic lock_written;
  logic power_on;
  logic fault_flag;
  logic any_locked;
  logic key_reg_wr;
  logic cpu_req;
  logic cpu_flash;
  logic cpu_bad;
  logic cpu_go;
  logic dbg_go_wr;
  logic dbg_go_er;
  logic [PW-1:0] cpu_page;
  logic [PW-1:0] pc_page;
  logic [PW-1:0] dbg_page;

  // key sequencer; a fault clears it along with store control, the lock byte sample and the power on flag
  fpeg_key_if kif ();

  fpeg_key u_key (
    .mclk(mclk),
    .rst_n(rst_n),
    .kif(kif)
  );

  // reset release through two flops
  // the raw reset only clears; release is retimed so no flop leaves reset alone
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // page lock test, shared by firmware and debug checks
  function automatic logic page_locked(input logic [PW-1:0] pg, input logic [7:0] n,
                                       input logic any);
    // compared as int so the test holds for any address width
    page_locked = (int'(pg) < int'(n)) // [RULE_19]
                  || (pg == LOCK_PAGE && any); // [RULE_04]
  endfunction

  assign any_locked = (locked_pages != 8'h00);
  assign cpu_page = cpu_addr[AW-1:fpeg_pkg::PAGE_SHIFT];
  assign pc_page = cpu_pc[AW-1:fpeg_pkg::PAGE_SHIFT];
  assign dbg_page = dbg_addr[AW-1:fpeg_pkg::PAGE_SHIFT];

  // an external move write reaches flash only with write enable set
  assign cpu_flash = cpu_xwr && psc[fpeg_pkg::WE_BIT]; // [RULE_09]
  assign cpu_req = cpu_flash || cpu_frd;

  // firmware fault decode
  always_comb
  begin
    cpu_bad = 1'b0;
    if (cpu_req && !sampled)
      cpu_bad = 1'b1;
    else if (cpu_req && !page_locked(pc_page, locked_pages, any_locked)
             && page_locked(cpu_page, locked_pages, any_locked))
      cpu_bad = 1'b1; // [RULE_20]
    // firmware may never erase the lock byte page, locked or not
    if (cpu_flash && psc[fpeg_pkg::EE_BIT] && cpu_page == LOCK_PAGE)
      cpu_bad = 1'b1;
    if (cpu_flash && !psc[fpeg_pkg::EE_BIT] && cpu_addr == LOCK_ADDR && lock_written)
      cpu_bad = 1'b1; // [RULE_05]
  end

  // flash operation proceeds only with the key open; otherwise it kills the key
  assign cpu_go = cpu_flash && !cpu_bad && kif.open; // [RULE_18]

  // debug checks: refusal is silent
  // before the lock byte is sampled every debug request except device erase is dropped
  assign dbg_go_wr = dbg_wr && sampled && !page_locked(dbg_page, locked_pages, any_locked)
                     && !(dbg_addr == LOCK_ADDR && lock_written); // [RULE_01]
  assign dbg_go_er = dbg_erase && sampled
                     && !page_locked(dbg_page, locked_pages, any_locked)
                     && !(dbg_page == LOCK_PAGE && any_locked); // [RULE_01]

  // fault request: one cycle, also clears store control, the key, the lock byte sample and the power on flag
  // back to back faults are merged: the first one resets everything anyway
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      fault <= 1'b0;
    else
      fault <= cpu_bad && !fault; // [RULE_02]
  end
  assign dev_reset_req = fault;

  assign kif.srst = fault;
  assign key_reg_wr = reg_wr && reg_addr == fpeg_pkg::KEY_ADDR;
  assign kif.wr = key_reg_wr;
  assign kif.wdata = reg_wdata;
  assign kif.attempt = cpu_flash && !cpu_bad;

  // program_store_control
  // only two bits are kept; the upper six are dropped on write and read as zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      psc <= fpeg_pkg::PSC_RST; // [RULE_11]
    else if (fault)
      psc <= fpeg_pkg::PSC_RST;
    else if (reg_wr && reg_addr == fpeg_pkg::PSC_ADDR)
      psc <= reg_wdata[1:0]; // [RULE_10]
  end

  // lock byte capture at reset only; later programming waits for the next reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sampled <= 1'b0;
      locked_pages <= 8'h00;
    end
    else if (fault)
      sampled <= 1'b0; // [RULE_06]
    else if (!sampled)
    begin
      sampled <= 1'b1;
      locked_pages <= ~lock_byte_in; // [RULE_22]
    end
  end

  // lock byte written tracking
  // device erase clears the mark; protection itself still waits for a reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      lock_written <= 1'b0;
    else if (dbg_dev_erase)
      lock_written <= 1'b0; // [RULE_05]
    else if (!sampled)
      lock_written <= (lock_byte_in != fpeg_pkg::LOCK_NONE);
    else if ((cpu_go && !psc[fpeg_pkg::EE_BIT] && cpu_addr == LOCK_ADDR)
             || (dbg_go_wr && dbg_addr == LOCK_ADDR))
      lock_written <= 1'b1;
  end

  // flash and external RAM strobes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fl_prog <= 1'b0;
      fl_erase <= 1'b0;
      fl_dev_erase <= 1'b0;
      fl_addr <= '0;
      fl_data <= 8'h00;
      xram_wr <= 1'b0;
      xram_addr <= '0;
      xram_data <= 8'h00;
      dbg_rd_ok <= 1'b0;
    end
    else
    begin
      fl_prog <= 1'b0;
      fl_erase <= 1'b0;
      fl_dev_erase <= dbg_dev_erase; // [RULE_03]
      xram_wr <= cpu_xwr && !psc[fpeg_pkg::WE_BIT]; // [RULE_08]
      // address and data follow the cpu every cycle; the strobe alone qualifies them
      xram_addr <= cpu_addr;
      xram_data <= cpu_wdata;
      dbg_rd_ok <= dbg_rd && sampled
                   && !page_locked(dbg_page, locked_pages, any_locked); // [RULE_01]
      if (cpu_go)
      begin
        // erase fills the page with the erased value; data is ignored
        fl_erase <= psc[fpeg_pkg::EE_BIT]; // [RULE_07] [RULE_21]
        fl_prog <= !psc[fpeg_pkg::EE_BIT]; // [RULE_08]
        fl_addr <= cpu_addr;
        fl_data <= cpu_wdata;
      end
      else if (dbg_go_wr || dbg_go_er)
      begin
        fl_erase <= dbg_go_er;
        fl_prog <= dbg_go_wr && !dbg_go_er;
        fl_addr <= dbg_addr;
        fl_data <= dbg_wdata; // [RULE_21]
      end
    end
  end

  // reset_source_reg flags; the fault flag outlives the fault reset
  // this register is read only here; writes to its address are ignored
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_on <= 1'b1;
      fault_flag <= 1'b0;
    end
    else if (fault)
    begin
      power_on <= 1'b0;
      fault_flag <= 1'b1; // [RULE_02]
    end
  end

  // interrupts wait while the array is busy
  // the hold is combinational so a pending interrupt cannot slip in at the strobe
  assign irq_hold = fl_busy || fl_prog || fl_erase || fl_dev_erase; // [RULE_12]

  // register read data, valid the cycle after the strobe
  // reads that miss the map return zero rather than the last value
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        fpeg_pkg::PSC_ADDR: reg_rdata <= {6'h00, psc}; // [RULE_10]
        fpeg_pkg::KEY_ADDR: reg_rdata <= {6'h00, kif.status};
        fpeg_pkg::RSRC_ADDR:
        begin
          reg_rdata <= 8'h00;
          reg_rdata[fpeg_pkg::POR_BIT] <= power_on;
          reg_rdata[fpeg_pkg::FAULT_BIT] <= fault_flag;
        end
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end
endmodule
`default_nettype wire

/* fpeg_flash_model.sv */
// behavioural flash array behind the guard: lock byte store and busy time
`timescale 1ns/1ps
`default_nettype none
module fpeg_flash_model #(
  parameter logic [15:0] LOCK_ADDR = 16'h3FFF
) (
  // clock
  input wire logic mclk,
  // array requests
  input wire logic fl_prog,
  input wire logic fl_erase,
  input wire logic fl_dev_erase,
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_data,
  // array status
  output logic [7:0] lock_byte_in,
  output logic fl_busy
);
  // non-volatile, so no reset: the lock byte survives device resets
  logic [7:0] lock = 8'hFF;
  logic [1:0] busy_cnt = 2'h0;
  always @(posedge mclk)
  begin
    if (fl_dev_erase)
      lock <= 8'hFF;
    else if (fl_erase && fl_addr[15:9] == LOCK_ADDR[15:9])
      lock <= 8'hFF;
    else if (fl_prog && fl_addr == LOCK_ADDR)
      lock <= lock & fl_data;
    // a slow array: busy for two cycles after each operation
    if (fl_prog || fl_erase || fl_dev_erase)
      busy_cnt <= 2'h2;
    else if (busy_cnt != 2'h0)
      busy_cnt <= busy_cnt - 2'h1;
  end
  assign lock_byte_in = lock;
  assign fl_busy = busy_cnt != 2'h0;
endmodule
`default_nettype wire

/* fpeg_guard_assertions.sv */
// concurrent checks for the flash program/erase guard
`timescale 1ns/1ps
`default_nettype none
module fpeg_guard_assertions #(
  parameter int AW = 16,
  parameter logic [15:0] LOCK_ADDR = 16'h3FFF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // requests
  input wire logic cpu_xwr,
  input wire logic cpu_frd,
  input wire logic [AW-1:0] cpu_addr,
  input wire logic [AW-1:0] cpu_pc,
  input wire logic dbg_wr,
  input wire logic dbg_rd,
  input wire logic dbg_erase,
  input wire logic dbg_dev_erase,
  input wire logic [AW-1:0] dbg_addr,
  // array and system
  input wire logic [7:0] lock_byte_in,
  input wire logic fl_busy,
  input wire logic fl_prog,
  input wire logic fl_erase,
  input wire logic fl_dev_erase,
  input wire logic xram_wr,
  input wire logic dev_reset_req,
  input wire logic irq_hold
);
  logic [1:0] psc;
  logic [7:0] lk;
  logic [1:0] cnt;
  logic fault_seen;
  logic we_req;
  logic ee_req;
  logic dbg_any;
  assign we_req = cpu_xwr && psc == 2'h1;
  assign ee_req = cpu_xwr && psc == 2'h3;
  assign dbg_any = dbg_wr || dbg_rd || dbg_erase || dbg_dev_erase;
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      psc <= 2'h0;
    else if (dev_reset_req)
      psc <= 2'h0;
    else if (reg_wr && reg_addr == fpeg_pkg::PSC_ADDR)
      psc <= reg_wdata[1:0];
  // protection copy: taken just after reset and after each fault reset
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      cnt <= 2'h0;
      lk <= 8'hFF;
      fault_seen <= 1'b0;
    end
    else
    begin
      if (cnt != 2'h3) cnt <= cnt + 2'h1;
      if (cnt != 2'h3 || dev_reset_req) lk <= lock_byte_in;
      if (dev_reset_req) fault_seen <= 1'b1;
    end
  function automatic logic lkd(input logic [AW-1:0] a);
    return ({1'b0, a[15:9]} < ~lk) || (lk != 8'hFF && a[15:9] == LOCK_ADDR[15:9]);
  endfunction
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence dbg_only;
    dbg_any && !cpu_xwr && !cpu_frd;
  endsequence
  sequence fw_bad_read;
    cpu_frd && lkd(cpu_addr) && !lkd(cpu_pc);
  endsequence
  dbg_silent_a: assert property (dbg_only |=> !dev_reset_req)
    else $error("debug request caused a reset");
  dev_erase_a: assert property (dbg_dev_erase && !cpu_xwr && !cpu_frd |=> fl_dev_erase)
    else $error("device erase not issued");
  fault_read_a: assert property (fw_bad_read |=> dev_reset_req)
    else $error("locked read gave no fault reset");
  dbg_locked_a: assert property (dbg_erase && !cpu_xwr && lkd(dbg_addr) |=> !fl_erase)
    else $error("debug erase of locked page");
  ram_path_a: assert property (
    cpu_xwr && !psc[fpeg_pkg::WE_BIT] && !dbg_wr && !dbg_erase |=> xram_wr && !fl_prog && !fl_erase)
    else $error("write without enable missed ram");
  prog_src_a: assert property (fl_prog |-> $past(dbg_wr) || $past(we_req))
    else $error("byte program without cause");
  erase_src_a: assert property (fl_erase |-> $past(dbg_erase) || $past(ee_req))
    else $error("page erase without cause");
  psc_read_a: assert property (
    reg_rd && reg_addr == fpeg_pkg::PSC_ADDR |=> reg_rdata == {6'h00, $past(psc)})
    else $error("store control read wrong");
  fault_flag_a: assert property (
    reg_rd && reg_addr == fpeg_pkg::RSRC_ADDR
    |=> reg_rdata[fpeg_pkg::FAULT_BIT] == $past(fault_seen))
    else $error("fault flag read wrong");
  irq_hold_a: assert property (irq_hold == (fl_busy || fl_prog || fl_erase || fl_dev_erase))
    else $error("interrupt hold wrong");
endmodule
bind fpeg_guard fpeg_guard_assertions #(.AW(AW), .LOCK_ADDR(LOCK_ADDR)) u_fpeg_guard_assertions (
  .mclk(mclk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .cpu_xwr(cpu_xwr), .cpu_frd(cpu_frd), .cpu_addr(cpu_addr), .cpu_pc(cpu_pc),
  .dbg_wr(dbg_wr), .dbg_rd(dbg_rd), .dbg_erase(dbg_erase), .dbg_dev_erase(dbg_dev_erase),
  .dbg_addr(dbg_addr),
  .lock_byte_in(lock_byte_in), .fl_busy(fl_busy), .fl_prog(fl_prog), .fl_erase(fl_erase),
  .fl_dev_erase(fl_dev_erase), .xram_wr(xram_wr), .dev_reset_req(dev_reset_req),
  .irq_hold(irq_hold)
);
`default_nettype wire

/* fpeg_guard_tb.sv */
// self-checking bench for the flash program/erase guard
`timescale 1ns/1ps
`default_nettype none
module fpeg_guard_tb;
  localparam logic [15:0] LA = 16'h3FFF;
  localparam logic [15:0] PC5 = 16'h0A00;
  localparam logic [7:0] KA = fpeg_pkg::KEY_ADDR;
  localparam logic [7:0] PA = fpeg_pkg::PSC_ADDR;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_xwr = 1'b0;
  logic cpu_frd = 1'b0;
  logic dbg_wr = 1'b0;
  logic dbg_rd = 1'b0;
  logic dbg_erase = 1'b0;
  logic dbg_dev_erase = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [15:0] cpu_pc = 16'h0000;
  logic [15:0] dbg_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] dbg_wdata = 8'h00;
  logic [7:0] reg_rdata, lock_byte_in, fl_data, xram_data;
  logic [15:0] fl_addr, xram_addr;
  logic fl_busy, fl_prog, fl_erase, fl_dev_erase, xram_wr, dbg_rd_ok, dev_reset_req, irq_hold;
  logic [15:0] rnd = 16'h77AE;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  always #10 mclk = ~mclk;
  fpeg_guard #(.LOCK_ADDR(LA)) u_fpeg_guard (
    .mclk(mclk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cpu_xwr(cpu_xwr), .cpu_frd(cpu_frd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_pc(cpu_pc),
    .dbg_wr(dbg_wr), .dbg_rd(dbg_rd), .dbg_erase(dbg_erase), .dbg_dev_erase(dbg_dev_erase),
    .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
    .lock_byte_in(lock_byte_in), .fl_busy(fl_busy), .fl_prog(fl_prog), .fl_erase(fl_erase),
    .fl_dev_erase(fl_dev_erase), .fl_addr(fl_addr), .fl_data(fl_data),
    .xram_wr(xram_wr), .xram_addr(xram_addr), .xram_data(xram_data),
    .dbg_rd_ok(dbg_rd_ok), .dev_reset_req(dev_reset_req), .irq_hold(irq_hold)
  );
  fpeg_flash_model #(.LOCK_ADDR(LA)) u_fpeg_flash_model (
    .mclk(mclk), .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_dev_erase(fl_dev_erase),
    .fl_addr(fl_addr), .fl_data(fl_data), .lock_byte_in(lock_byte_in), .fl_busy(fl_busy)
  );
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic reg_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask
  task automatic unlock;
    reg_w(KA, fpeg_pkg::KEY_CODE1);
    reg_w(KA, fpeg_pkg::KEY_CODE2);
  endtask
  // k: 0 xwr, 1 frd, 2 dbg wr, 3 dbg rd, 4 dbg erase, 5 dbg device erase
  // e: prog, erase, device erase, ram write, debug read ok, fault reset
  task automatic req(input int k, input logic [15:0] a, input logic [7:0] d,
                     input logic [15:0] p, input logic [5:0] e);
    @(posedge mclk);
    cpu_addr <= a;
    dbg_addr <= a;
    cpu_wdata <= d;
    dbg_wdata <= d;
    cpu_pc <= p;
    {cpu_xwr, cpu_frd, dbg_wr, dbg_rd, dbg_erase, dbg_dev_erase} <= 6'h20 >> k;
    @(posedge mclk);
    {cpu_xwr, cpu_frd, dbg_wr, dbg_rd, dbg_erase, dbg_dev_erase} <= 6'h00;
    #1 chk(16'({fl_prog, fl_erase, fl_dev_erase, xram_wr, dbg_rd_ok, dev_reset_req}), 16'(e));
  endtask
  task automatic do_reset;
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      wrap_up;
    end
  end
  initial
  begin
    do_reset;
    rd(PA, 8'h00);
    chk(16'(irq_hold), 16'h0000);
    rd(fpeg_pkg::RSRC_ADDR, 8'h02);
    rd(8'h55, 8'h00);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      reg_w(PA, rnd[7:0]);
      rd(PA, {6'h00, rnd[1:0]});
    end
    reg_w(PA, 8'h03);
    rd(KA, 8'h00);
    reg_w(KA, fpeg_pkg::KEY_CODE1);
    rd(KA, 8'h01);
    reg_w(KA, fpeg_pkg::KEY_CODE2);
    rd(KA, 8'h02);
    rnd = lfsr(rnd);
    req(0, {3'h0, rnd[12:0]}, 8'h5A, PC5, 6'h10);
    chk(fl_addr, {3'h0, rnd[12:0]});
    rd(KA, 8'h00);
    reg_w(PA, 8'h01);
    unlock;
    req(0, {3'h0, rnd[12:0]}, rnd[15:8], PC5, 6'h20);
    chk(fl_addr, {3'h0, rnd[12:0]});
    chk(16'(fl_data), 16'(rnd[15:8]));
    chk(16'(irq_hold), 16'h0001);
    reg_w(PA, 8'h00);
    req(0, 16'h1234, 8'hC3, PC5, 6'h04);
    chk(xram_addr, 16'h1234);
    chk(16'(xram_data), 16'h00C3);
    reg_w(PA, 8'h01);
    req(0, 16'h0400, 8'h00, PC5, 6'h00);
    rd(KA, 8'h03);
    do_reset;
    reg_w(PA, 8'h01);
    unlock;
    req(0, LA, 8'hFD, PC5, 6'h20);
    req(1, 16'h0200, 8'h00, PC5, 6'h00);
    unlock;
    req(0, LA, 8'h00, PC5, 6'h01);
    repeat (4) @(posedge mclk);
    reg_w(fpeg_pkg::RSRC_ADDR, 8'h02);
    rd(fpeg_pkg::RSRC_ADDR, 8'h40);
    req(3, 16'h0200, 8'h00, PC5, 6'h00);
    req(3, PC5, 8'h00, PC5, 6'h02);
    req(1, 16'h0400, 8'h00, PC5, 6'h00);
    req(1, LA, 8'h00, 16'h0000, 6'h00);
    req(1, LA, 8'h00, PC5, 6'h01);
    repeat (4) @(posedge mclk);
    req(4, 16'h0000, 8'h00, PC5, 6'h00);
    req(2, LA, 8'h00, PC5, 6'h00);
    req(5, 16'h0000, 8'h00, PC5, 6'h08);
    do_reset;
    req(3, 16'h0200, 8'h00, PC5, 6'h02);
    req(2, 16'h0A10, 8'h3C, PC5, 6'h20);
    chk(16'(fl_data), 16'h003C);
    req(4, 16'h0A00, 8'h00, PC5, 6'h10);
    wrap_up;
  end
endmodule
`default_nettype wire
